//--- ejm_pkg.sv
// Package: constants and carrier types for the ejector process data block
package ejm_pkg;
    // ****************************************
    // Image offsets
    // ****************************************
    localparam int OFF_IN_STATUS  = 0;
    localparam int OFF_IN_VALUE   = 1;
    localparam int OFF_IN_WORD_HI = 2;
    localparam int OFF_IN_WORD_LO = 3;
    localparam int OFF_OUT_CTRL   = 0;
    localparam int OFF_OUT_PRESS  = 1;
    // ****************************************
    // Input byte 0 fields
    // ****************************************
    localparam int IN_PART     = 0;
    localparam int IN_AIRSAVE  = 1;
    localparam int IN_LEARN    = 3;
    localparam int IN_SEL_ACK  = 4;
    localparam int IN_GREEN    = 5;
    localparam int IN_YELLOW   = 6;
    localparam int IN_RED      = 7;
    // ****************************************
    // Output byte 0 fields
    // ****************************************
    localparam int OUT_SUCTION = 0;
    localparam int OUT_BLOW    = 1;
    localparam int OUT_SETTING = 2;
    localparam int OUT_LEARN   = 3;
    localparam int OUT_SEL_LO  = 4;
    localparam int OUT_SEL_HI  = 5;
    localparam int OUT_PROF_LO = 6;
    localparam int OUT_PROF_HI = 7;
    // ****************************************
    // Monitoring flag bits
    // ****************************************
    localparam int CM_VALVE    = 0;
    localparam int CM_EVAC     = 1;
    localparam int CM_LEAK     = 2;
    localparam int CM_H1_MISS  = 3;
    localparam int CM_DYN      = 4;
    localparam int CM_SUPPLY   = 5;
    localparam int CM_SYSP     = 7;
    localparam int CM_CYCLE_N  = 4;
    // ****************************************
    // Values and timing
    // ****************************************
    localparam logic [7:0]  CMD_STORE    = 8'h05;
    localparam logic [7:0]  PRESS_UNUSED = 8'h00;
    localparam logic [7:0]  BYTE_ZERO    = 8'h00;
    localparam logic [15:0] WORD_ZERO    = 16'h0000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SEL_DELAY_NS  = 1000;
    localparam int SEL_DELAY_CYC = (SEL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MEAS_N        = 4;
    localparam int MEAS_T0       = 0;
    localparam int MEAS_T1       = 1;
    localparam int MEAS_LEAK     = 2;
    localparam int MEAS_AIR      = 3;

    typedef struct packed {
        logic [7:0] press;
        logic [7:0] ctrl;
    } ejm_pd_out_t;

    typedef struct packed {
        logic [7:0] word_lo;
        logic [7:0] word_hi;
        logic [7:0] value;
        logic [7:0] status;
    } ejm_pd_in_t;

    typedef struct packed {
        logic [15:0] v16;
        logic [7:0]  v8;
    } ejm_pair_t;

    typedef struct packed {
        logic h1_miss;
        logic leak;
        logic evac;
        logic valve;
    } ejm_cm_event_t;
endpackage : ejm_pkg

//--- ejm_cycle_latch.sv
// Measurement holder cleared at suction cycle start and loaded when measured
`timescale 1ns/1ps
module ejm_cycle_latch #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         reset_n,
    // Control
    input  wire logic         clear,
    input  wire logic         load,
    input  wire logic [W-1:0] din,
    // Held value
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] val;
    } ejm_latch_state_t;

    ejm_latch_state_t st_reg;
    ejm_latch_state_t st_next;

    // Clear wins: a measurement cannot belong to a cycle that just began
    always_comb begin
        st_next = st_reg;
        if (clear) begin
            st_next.val = '0;
        end else if (load) begin
            st_next.val = din;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.val;
endmodule : ejm_cycle_latch

//--- ejm_pair_select.sv
// Value pair multiplexer with delayed switch-over and acknowledge
`timescale 1ns/1ps
module ejm_pair_select #(
    parameter int DELAY = ejm_pkg::SEL_DELAY_CYC
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              reset_n,
    // Selection and sources
    input  wire logic [1:0]        value_pair_select,
    input  wire ejm_pkg::ejm_pair_t pairs [4],
    // Result
    output ejm_pkg::ejm_pair_t     pair_out,
    output logic                   value_pair_select_ack
);
    typedef struct packed {
        logic [1:0]          active;
        logic [15:0]         cnt;
        ejm_pkg::ejm_pair_t  data;
        logic                ack;
    } ejm_sel_state_t;

    ejm_sel_state_t st_reg;
    ejm_sel_state_t st_next;

    // The delay mimics the switch time a controller sees on a real line
    always_comb begin
        st_next = st_reg;
        if (value_pair_select != st_reg.active) begin
            if (st_reg.cnt >= 16'(DELAY - 1)) begin
                st_next.active = value_pair_select;
                st_next.cnt    = '0;
            end else begin
                st_next.cnt = st_reg.cnt + 16'h0001;
            end
        end else begin
            st_next.cnt = '0;
        end
        st_next.data = pairs[st_next.active];
        st_next.ack  = (st_next.active != 2'h0);
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pair_out              = st_reg.data;
    assign value_pair_select_ack = st_reg.ack;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    ack_follows_sel_a: assert property (
        (value_pair_select == 2'h0) [*8] |-> ##[0:200] !value_pair_select_ack)
        else $error("acknowledge did not return to zero");
endmodule : ejm_pair_select

//--- ejm_process_data.sv
// Ejector process data image with condition and energy monitoring
// Summary of operation
// - Status bit 0 shows part held, bit 1 shows air-saving threshold reached.
// - Status bits 5, 6, 7 show green, yellow and red traffic light.
// - Newer revision: value byte 1, value word high in byte 2, low in 3.
// - Suction sets part bit above threshold; cleared below threshold minus hysteresis.
// - Any monitoring warning turns the light from green to yellow at once.
// - Monitoring word: valve, evacuation, leakage, air-saving, dynamic, supply, system pressure.
// - Bits 0-3 cleared at cycle start, set once, held until suction ends.
// - Bit 4 cleared at power-up, changed only on a new dynamic pressure value.
// - Bits 5 and 7 follow supply voltage and system pressure continuously.
// - Evacuation times and leakage reset at cycle start, loaded when measured.
// - Absolute air use reset at cycle start, updated until blow-off ends.
// - Percentage air and energy taken only at next cycle start.
// - Menu changes mirror automatically; system command 5 also triggers mirroring.
// - Revision 1.1 exchanges four input and two output bytes; 1.0 one each.
// - Select acknowledge is 0 for pair 00 and 1 otherwise, after a delay.
`timescale 1ns/1ps
module ejm_process_data #(
    parameter int         SEL_DELAY    = ejm_pkg::SEL_DELAY_CYC,
    parameter logic [7:0] SYS_PRESS_LO = 8'h28,
    parameter logic [7:0] SYS_PRESS_HI = 8'h50
) (
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   reset_n,
    // Process data image
    input  wire logic                   pd_out_valid,
    input  wire ejm_pkg::ejm_pd_out_t   process_output_image,
    input  wire logic                   rev_1_1,
    output ejm_pkg::ejm_pd_in_t         process_input_image,
    // Sensing and thresholds
    input  wire logic [15:0]            vacuum_level,
    input  wire logic [7:0]             input_pressure,
    input  wire logic [7:0]             supply_voltage,
    input  wire logic [15:0]            part_present_threshold,
    input  wire logic [15:0]            part_present_hysteresis,
    input  wire logic [15:0]            air_saving_threshold,
    // Monitoring events and measurements
    input  wire ejm_pkg::ejm_cm_event_t cm_events,
    input  wire logic                   supply_out_of_range,
    input  wire logic                   error_active,
    input  wire logic                   dyn_press_valid,
    input  wire logic [15:0]            dyn_press_value,
    input  wire logic [3:0]             meas_valid,
    input  wire logic [15:0]            meas_value [4],
    input  wire logic [7:0]             leak_rate,
    input  wire logic [7:0]             air_pct_running,
    input  wire logic [15:0]            energy_running,
    input  wire logic                   auto_threshold_learn_ack,
    // Parameter mirroring
    input  wire logic                   menu_param_change,
    input  wire logic                   sys_cmd_valid,
    input  wire logic [7:0]             sys_cmd_value,
    output logic                        store_params_to_master,
    // Actuator and monitoring outputs
    output logic                        suction_on,
    output logic                        blowoff_on,
    output logic                        setting_mode,
    output logic                        auto_threshold_learn,
    output logic [1:0]                  production_profile_index,
    output logic [7:0]                  ext_system_pressure,
    output logic [7:0]                  monitoring_warning_flags,
    output logic [15:0]                 meas_out [4],
    output logic [7:0]                  air_pct_last,
    output logic [15:0]                 energy_last
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  press;
        logic        part;
        logic        airsave;
        logic [2:0]  light;
        logic [7:0]  cm;
        logic        in_cycle;
        logic        air_open;
        logic [7:0]  air_pct;
        logic [15:0] energy;
        logic [15:0] dyn_last;
        logic        store;
    } ejm_state_t;

    ejm_state_t st_reg;
    ejm_state_t st_next;

    logic               cycle_start;
    logic               cycle_end;
    logic [15:0]        part_low;
    logic [15:0]        save_low;
    logic [1:0]         sel_eff;
    logic [3:0]         meas_clear;
    logic [3:0]         meas_load;
    ejm_pkg::ejm_pair_t pairs [4];
    ejm_pkg::ejm_pair_t pair_out;
    logic               sel_ack;

    // Effective control byte: revision 1.0 carries no learn or select bits
    logic [7:0] ctrl_eff;
    assign ctrl_eff = rev_1_1 ? st_reg.ctrl
                    : (st_reg.ctrl & 8'hc7);

    assign cycle_start = ctrl_eff[ejm_pkg::OUT_SUCTION] && !st_reg.in_cycle;
    assign cycle_end   = !ctrl_eff[ejm_pkg::OUT_SUCTION] && st_reg.in_cycle;
    assign sel_eff     = ctrl_eff[ejm_pkg::OUT_SEL_HI:ejm_pkg::OUT_SEL_LO];

    // Floor at zero so a large hysteresis cannot wrap the release level
    assign part_low = (part_present_hysteresis > part_present_threshold) ? ejm_pkg::WORD_ZERO
                    : part_present_threshold - part_present_hysteresis;
    assign save_low = (part_present_hysteresis > air_saving_threshold) ? ejm_pkg::WORD_ZERO
                    : air_saving_threshold - part_present_hysteresis;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_next       = st_reg;
        st_next.store = 1'b0;
        if (pd_out_valid) begin
            st_next.ctrl  = process_output_image.ctrl;
            st_next.press = rev_1_1 ? process_output_image.press
                          : ejm_pkg::PRESS_UNUSED;
        end
        if (vacuum_level > part_present_threshold) begin
            st_next.part = 1'b1;
        end else if (vacuum_level < part_low) begin
            st_next.part = 1'b0;
        end
        if (vacuum_level > air_saving_threshold) begin
            st_next.airsave = 1'b1;
        end else if (vacuum_level < save_low) begin
            st_next.airsave = 1'b0;
        end
        st_next.in_cycle = ctrl_eff[ejm_pkg::OUT_SUCTION];
        if (cycle_start) begin
            // Set wins over the start clear: an event at the start edge belongs to the new cycle
            st_next.cm[ejm_pkg::CM_CYCLE_N-1:0] = cm_events;
            st_next.air_open = 1'b1;
            st_next.air_pct  = air_pct_running;
            st_next.energy   = energy_running;
        end else if (st_reg.in_cycle && ctrl_eff[ejm_pkg::OUT_SUCTION]) begin
            // Sticky within the cycle, frozen once suction drops
            st_next.cm[ejm_pkg::CM_CYCLE_N-1:0] = st_reg.cm[ejm_pkg::CM_CYCLE_N-1:0] | cm_events;
        end
        if (!ctrl_eff[ejm_pkg::OUT_SUCTION] && !ctrl_eff[ejm_pkg::OUT_BLOW] && !st_reg.in_cycle) begin
            st_next.air_open = 1'b0;
        end
        if (dyn_press_valid) begin
            st_next.dyn_last = dyn_press_value;
            st_next.cm[ejm_pkg::CM_DYN] = (dyn_press_value > part_low)
                                       && (dyn_press_value < air_saving_threshold);
        end
        st_next.cm[ejm_pkg::CM_SUPPLY] = supply_out_of_range;
        st_next.cm[ejm_pkg::CM_SYSP]   = (st_next.press != ejm_pkg::PRESS_UNUSED)
                                      && ((st_next.press < SYS_PRESS_LO) || (st_next.press > SYS_PRESS_HI));
        if (error_active) begin
            st_next.light = 3'h4;
        end else if (st_next.cm != ejm_pkg::BYTE_ZERO) begin
            st_next.light = 3'h2;
        end else begin
            st_next.light = 3'h1;
        end
        if (menu_param_change || (sys_cmd_valid && sys_cmd_value == ejm_pkg::CMD_STORE)) begin
            st_next.store = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg       <= '0;
            st_reg.light <= 3'h1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // Cycle measurements
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < ejm_pkg::MEAS_N; gi++) begin : g_meas
            assign meas_clear[gi] = cycle_start;
            if (gi == ejm_pkg::MEAS_AIR) begin : g_air
                assign meas_load[gi] = meas_valid[gi] && st_reg.air_open;
            end else begin : g_cm
                assign meas_load[gi] = meas_valid[gi] && st_reg.in_cycle;
            end
            ejm_cycle_latch #(
                .W (16)
            ) u_latch (
                .ref_clk (ref_clk),
                .reset_n (reset_n),
                .clear   (meas_clear[gi]),
                .load    (meas_load[gi]),
                .din     (meas_value[gi]),
                .q       (meas_out[gi])
            );
        end
    endgenerate

    // ****************************************
    // Value pair selection
    // ****************************************
    always_comb begin
        pairs[0] = '{v16: vacuum_level, v8: input_pressure};
        pairs[1] = '{v16: meas_out[ejm_pkg::MEAS_T1], v8: st_reg.cm};
        pairs[2] = '{v16: st_reg.dyn_last, v8: leak_rate};
        pairs[3] = '{v16: meas_out[ejm_pkg::MEAS_AIR], v8: supply_voltage};
    end

    ejm_pair_select #(
        .DELAY (SEL_DELAY)
    ) u_sel (
        .ref_clk               (ref_clk),
        .reset_n               (reset_n),
        .value_pair_select     (sel_eff),
        .pairs                 (pairs),
        .pair_out              (pair_out),
        .value_pair_select_ack (sel_ack)
    );

    // ****************************************
    // Outputs
    // ****************************************
    logic learn_ack_reg;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            learn_ack_reg <= 1'b0;
        end else begin
            learn_ack_reg <= auto_threshold_learn_ack && rev_1_1;
        end
    end

    always_comb begin
        process_input_image                              = '0;
        process_input_image.status[ejm_pkg::IN_PART]     = st_reg.part;
        process_input_image.status[ejm_pkg::IN_AIRSAVE]  = st_reg.airsave;
        process_input_image.status[ejm_pkg::IN_LEARN]    = learn_ack_reg;
        process_input_image.status[ejm_pkg::IN_SEL_ACK]  = sel_ack && rev_1_1;
        process_input_image.status[ejm_pkg::IN_RED:ejm_pkg::IN_GREEN] = st_reg.light;
        if (rev_1_1) begin
            process_input_image.value   = pair_out.v8;
            process_input_image.word_hi = pair_out.v16[15:8];
            process_input_image.word_lo = pair_out.v16[7:0];
        end
    end

    assign suction_on               = ctrl_eff[ejm_pkg::OUT_SUCTION];
    assign blowoff_on               = ctrl_eff[ejm_pkg::OUT_BLOW];
    assign setting_mode             = ctrl_eff[ejm_pkg::OUT_SETTING];
    assign auto_threshold_learn     = ctrl_eff[ejm_pkg::OUT_LEARN];
    assign production_profile_index = ctrl_eff[ejm_pkg::OUT_PROF_HI:ejm_pkg::OUT_PROF_LO];
    assign ext_system_pressure      = st_reg.press;
    assign monitoring_warning_flags = st_reg.cm;
    assign air_pct_last             = st_reg.air_pct;
    assign energy_last              = st_reg.energy;
    assign store_params_to_master   = st_reg.store;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence start_seq;
        !st_reg.in_cycle ##1 st_reg.in_cycle;
    endsequence

    sequence end_seq;
        st_reg.in_cycle ##1 !st_reg.in_cycle;
    endsequence

    light_onehot_a: assert property ($onehot(st_reg.light))
        else $error("light not one-hot");
    light_yellow_a: assert property (
        (!error_active && st_next.cm != 8'h00) |=> st_reg.light == 3'h2)
        else $error("warning did not give yellow");
    part_set_a: assert property (
        (vacuum_level > part_present_threshold) |=> process_input_image.status[0])
        else $error("part bit not set");
    part_clear_a: assert property (
        (vacuum_level < part_low && vacuum_level <= part_present_threshold) |=> !st_reg.part)
        else $error("part bit not cleared");
    cycle_clear_a: assert property (
        start_seq |-> st_reg.cm[3:0] == $past(cm_events))
        else $error("cycle flags not cleared");
    cycle_hold_a: assert property (
        end_seq ##1 !st_reg.in_cycle [*2] |-> $stable(st_reg.cm[3:0]))
        else $error("cycle flags changed after suction");
    dyn_hold_a: assert property (
        !dyn_press_valid |=> $stable(st_reg.cm[4]))
        else $error("dynamic flag changed without measurement");
    store_cmd_a: assert property (
        (sys_cmd_valid && sys_cmd_value == 8'h05) |=> store_params_to_master)
        else $error("store not triggered");
    legacy_zero_a: assert property (
        !rev_1_1 |-> process_input_image.value == 8'h00 && process_input_image.word_hi == 8'h00)
        else $error("legacy image bytes not zero");
endmodule : ejm_process_data

//--- ejm_master_model.sv
// Master port model that frames the process output image toward the device
`timescale 1ns/1ps
module ejm_master_model (
    // Clock and device status byte
    input  wire logic            ref_clk,
    input  wire logic [7:0]      status,
    // Output image toward the device
    output logic                 pd_out_valid,
    output ejm_pkg::ejm_pd_out_t process_output_image
);
    ejm_pkg::ejm_pd_out_t cur;

    initial begin
        cur = '0;
        pd_out_valid = 1'b0;
        process_output_image = '1;
    end

    // Image is valid for its frame cycle only; outside it the lines scramble
    task automatic send(input logic [7:0] ctrl, input logic [7:0] press);
        @(negedge ref_clk);
        cur = '{press: press, ctrl: ctrl};
        process_output_image = cur;
        pd_out_valid = 1'b1;
        @(negedge ref_clk);
        pd_out_valid = 1'b0;
        process_output_image = ~cur;
    endtask : send

    task automatic wait_ack(input logic v, output logic ok);
        ok = 1'b0;
        for (int i = 0; i < 50 && !ok; i++) begin
            @(negedge ref_clk);
            ok = (status[ejm_pkg::IN_SEL_ACK] === v);
        end
    endtask : wait_ack

    // Back to pair 00 first, so a raised acknowledge always belongs to the new pair
    task automatic pick(input logic [1:0] sel, output logic ok);
        logic ok0;
        send({cur.ctrl[7:6], 2'b00, cur.ctrl[3:0]}, cur.press);
        wait_ack(1'b0, ok0);
        send({cur.ctrl[7:6], sel, cur.ctrl[3:0]}, cur.press);
        wait_ack(sel != 2'b00, ok);
        ok = ok & ok0;
    endtask : pick
endmodule : ejm_master_model

//--- ejm_process_data_tb_top.sv
// Self-checking testbench for the ejector process data block
`timescale 1ns/1ps
module ejm_process_data_tb_top;
    logic ref_clk, reset_n, pd_out_valid, rev_1_1, supply_out_of_range, error_active, ok;
    logic dyn_press_valid, auto_threshold_learn_ack, menu_param_change, sys_cmd_valid;
    logic store_params_to_master, suction_on, blowoff_on, setting_mode, auto_threshold_learn;
    logic [1:0] production_profile_index;
    logic [3:0] meas_valid;
    logic [7:0] input_pressure, supply_voltage, leak_rate, air_pct_running, sys_cmd_value;
    logic [7:0] ext_system_pressure, monitoring_warning_flags, air_pct_last;
    logic [15:0] vacuum_level, part_present_threshold, part_present_hysteresis, air_saving_threshold;
    logic [15:0] dyn_press_value, energy_running, energy_last, meas_value [4], meas_out [4];
    ejm_pkg::ejm_pd_out_t process_output_image;
    ejm_pkg::ejm_pd_in_t process_input_image;
    ejm_pkg::ejm_cm_event_t cm_events;
    wire [7:0] st = process_input_image.status;
    int bad_count = 0;
    int compares = 0;
    int n;

    ejm_process_data #(.SEL_DELAY(4)) DUT (.ref_clk, .reset_n, .pd_out_valid, .process_output_image, .rev_1_1,
        .process_input_image, .vacuum_level, .input_pressure, .supply_voltage, .part_present_threshold,
        .part_present_hysteresis, .air_saving_threshold, .cm_events, .supply_out_of_range, .error_active,
        .dyn_press_valid, .dyn_press_value, .meas_valid, .meas_value, .leak_rate, .air_pct_running,
        .energy_running, .auto_threshold_learn_ack, .menu_param_change, .sys_cmd_valid, .sys_cmd_value,
        .store_params_to_master, .suction_on, .blowoff_on, .setting_mode, .auto_threshold_learn,
        .production_profile_index, .ext_system_pressure, .monitoring_warning_flags, .meas_out,
        .air_pct_last, .energy_last);
    ejm_master_model MST (.ref_clk, .status(st), .pd_out_valid, .process_output_image);

    always #5 ref_clk = ~ref_clk;

    task automatic tick(input int k);
        repeat (k) @(negedge ref_clk);
    endtask : tick

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic mirror(input logic menu, input logic [7:0] cmd, output int k);
        k = 0;
        menu_param_change = menu;
        sys_cmd_valid = !menu;
        sys_cmd_value = cmd;
        repeat (4) begin
            @(negedge ref_clk);
            {menu_param_change, sys_cmd_valid} = 2'b00;
            if (store_params_to_master === 1'b1) k++;
        end
    endtask : mirror

    task automatic stop_test;
        $display("Mismatches %0d of %0d compares", bad_count, compares);
        if (bad_count == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test

    // Whole sequence needs about 1 us; a hang is cut well after that
    initial begin
        #100us;
        bad_count++;
        stop_test;
    end

    initial begin
        {ref_clk, reset_n, supply_out_of_range, error_active, dyn_press_valid, meas_valid, cm_events} = '0;
        {auto_threshold_learn_ack, menu_param_change, sys_cmd_valid, sys_cmd_value} = '0;
        {supply_voltage, leak_rate, air_pct_running, dyn_press_value, energy_running, vacuum_level} = '0;
        meas_value = '{default: 16'h0000};
        rev_1_1 = 1'b1;
        input_pressure = 8'h3c;
        part_present_threshold = 16'h0100;
        part_present_hysteresis = 16'h0020;
        air_saving_threshold = 16'h0200;
        tick(2);
        chk(st, 8'h20);
        chk(monitoring_warning_flags, 8'h00);
        reset_n = 1'b1;
        for (int p = 0; p < 4; p++) begin
            MST.send({p[1:0], 6'h01}, 8'h33);
            tick(1);
            chk(production_profile_index, p[1:0]);
        end
        chk(suction_on, 1'b1);
        chk(ext_system_pressure, 8'h33);
        vacuum_level = 16'h0150;
        tick(2);
        chk(st[1:0], 2'b01);
        chk(st[7:5], 3'b001);
        vacuum_level = 16'h0250;
        tick(2);
        chk(st[1:0], 2'b11);
        cm_events.evac = 1'b1;
        dyn_press_valid = 1'b1;
        dyn_press_value = 16'h0150;
        air_pct_running = 8'h21;
        energy_running = 16'h1234;
        tick(1);
        cm_events = '0;
        dyn_press_valid = 1'b0;
        tick(2);
        chk(monitoring_warning_flags, 8'h12);
        chk(st[7:5], 3'b010);
        chk(air_pct_last, 8'h00);
        chk(energy_last, 16'h0000);
        supply_out_of_range = 1'b1;
        error_active = 1'b1;
        tick(2);
        chk(monitoring_warning_flags[5], 1'b1);
        chk(st[7:5], 3'b100);
        {supply_out_of_range, error_active} = 2'b00;
        tick(2);
        chk(monitoring_warning_flags[5], 1'b0);
        MST.send(8'h82, 8'h33);
        chk(blowoff_on, 1'b1);
        vacuum_level = 16'h00d0;
        tick(2);
        chk(st[0], 1'b0);
        MST.send(8'h80, 8'h33);
        tick(3);
        MST.send(8'h81, 8'h33);
        tick(3);
        chk(monitoring_warning_flags, 8'h10);
        chk(air_pct_last, 8'h21);
        chk(energy_last, 16'h1234);
        meas_value[1] = 16'h0abc;
        meas_value[3] = 16'h0077;
        meas_valid = 4'b1010;
        tick(1);
        meas_valid = 4'b0000;
        tick(2);
        chk(meas_out[1], 16'h0abc);
        chk(meas_out[3], 16'h0077);
        MST.send(8'h81, 8'h60);
        chk(monitoring_warning_flags[7], 1'b1);
        MST.send(8'h81, 8'h00);
        chk(monitoring_warning_flags[7], 1'b0);
        mirror(1'b0, 8'h05, n);
        chk(16'(n), 16'h0001);
        mirror(1'b0, 8'h04, n);
        chk(16'(n), 16'h0000);
        mirror(1'b1, 8'h00, n);
        chk(16'(n), 16'h0001);
        chk({process_input_image.value, process_input_image.word_hi}, 16'h3c00);
        chk(process_input_image.word_lo, 8'hd0);
        MST.pick(2'b01, ok);
        chk(ok, 1'b1);
        chk(process_input_image.value, 8'h10);
        chk({process_input_image.word_hi, process_input_image.word_lo}, 16'h0abc);
        MST.pick(2'b10, ok);
        chk(ok, 1'b1);
        chk({process_input_image.word_hi, process_input_image.word_lo}, 16'h0150);
        MST.pick(2'b00, ok);
        chk({ok, st[4]}, 2'b10);
        auto_threshold_learn_ack = 1'b1;
        tick(2);
        chk(st[3], 1'b1);
        rev_1_1 = 1'b0;
        MST.send(8'h8d, 8'h33);
        tick(2);
        chk({ext_system_pressure, process_input_image.value}, 16'h0000);
        chk({auto_threshold_learn, st[3]}, 2'b00);
        chk(setting_mode, 1'b1);
        stop_test;
    end
endmodule : ejm_process_data_tb_top
